/* lpc_pkg.sv */
// Constants, register map and sleep timing tables for the low-power calibration and trim bank.
// Overview of operation
// - The three-bit idle interval code picks a sleep length of 1,152 up to 1,099,511,627,904 clock periods and resets to code 4.
// - The idle interval only matters while low-power calibration is on and pin-paced sleep is off.
// - The two-bit settle interval code picks a post-wake wait of 1,152, 33,554,560, 268,435,584 or 2,147,483,776 periods and resets to code 1.
// - With pin-paced sleep at 0 the scheduler runs by itself and times each sleep from the idle interval.
// - With pin-paced sleep at 1 the offline core sleeps while the trigger is high and wakes once it is low.
// - The low-power enable resets to 0 and only takes effect while background calibration is also on.
// - An eight-bit gain adjust value trims all cores together, resets to 0 and loads from the factory fuse store on its first valid.
// - A four-bit reference adjust field in bits 3:0 resets to 0, loads the factory value on the first fuse valid and is readable and writable.
// - Each of inputs A to C has an eight-bit termination trim that loads its factory value and is readable and writable.
// - The trigger comes from the trigger pin when the trigger source bit is 1 and from the software trigger bit when it is 0.
package lpc_pkg;

    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 41;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [8:0] OFS_CAL_CONFIG = 9'h06B;
    localparam logic [8:0] OFS_SOFT_TRIG  = 9'h06C;
    localparam logic [8:0] OFS_LP_CONTROL = 9'h06E;
    localparam logic [8:0] OFS_GAIN       = 9'h07A;
    localparam logic [8:0] OFS_REFERENCE  = 9'h07C;
    localparam logic [8:0] OFS_TERM_A     = 9'h07E;
    localparam logic [8:0] OFS_TERM_B     = 9'h07F;
    localparam logic [8:0] OFS_TERM_C     = 9'h080;
    localparam logic [8:0] OFS_BG_CONTROL = 9'h0F0;
    localparam logic [8:0] OFS_LP_STATUS  = 9'h0F1;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned LOWPOWER_CAL_ON_BIT     = 0;
    localparam int unsigned LP_PIN_BIT    = 1;
    localparam int unsigned LP_SETTLE_LSB = 3;
    localparam int unsigned LP_IDLE_LSB   = 5;
    localparam int unsigned TRIG_SRC_BIT  = 0;
    localparam int unsigned SOFT_TRIG_BIT = 0;
    localparam int unsigned BG_ON_BIT     = 0;
    localparam int unsigned REF_W         = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_LP_CONTROL = 8'h88;
    localparam logic [7:0] RST_CAL_CONFIG = 8'h00;
    localparam logic [7:0] RST_SOFT_TRIG  = 8'h01;
    localparam logic [7:0] RST_BG_CONTROL = 8'h00;
    localparam logic [7:0] RST_FUSE_PLAIN = 8'h00;

    // ************************************************************
    // Sleep and settle lengths in device clock periods
    // ************************************************************
    localparam logic [40:0] IDLE_CNT_0 = 41'h00000000480;
    localparam logic [40:0] IDLE_CNT_1 = 41'h00000400080;
    localparam logic [40:0] IDLE_CNT_2 = 41'h00002000080;
    localparam logic [40:0] IDLE_CNT_3 = 41'h00010000080;
    localparam logic [40:0] IDLE_CNT_4 = 41'h00080000080;
    localparam logic [40:0] IDLE_CNT_5 = 41'h00400000080;
    localparam logic [40:0] IDLE_CNT_6 = 41'h02000000080;
    localparam logic [40:0] IDLE_CNT_7 = 41'h10000000080;

    typedef enum logic [2:0] {
        LPC_OFF    = 3'b000,
        LPC_SLEEP  = 3'b001,
        LPC_SETTLE = 3'b010,
        LPC_CAL    = 3'b011
    } lpc_state_t;

endpackage

/* lpc_regs.sv */
// Low-power calibration scheduler and factory trim register bank.
`timescale 1ns/1ps
`default_nettype none
module lpc_regs
    import lpc_pkg::*;
#(
    parameter int unsigned IN_COUNT = 3
)
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Factory fuse values
    input  wire logic [DATA_W-1:0] fuse_gain,
    input  wire logic [REF_W-1:0]  fuse_reference,
    input  wire logic [DATA_W-1:0] fuse_term [IN_COUNT],
    input  wire logic              fuse_valid,
    // Pins
    input  wire logic              trigger_pin,
    // Calibration engine handshake
    input  wire logic              cal_done,
    // Analogue controls
    output logic      [DATA_W-1:0] core_gain_adjust,
    output logic      [REF_W-1:0]  reference_adjust,
    output logic      [DATA_W-1:0] input_termination [IN_COUNT],
    output logic                   core_sleep,
    output logic                   cal_start
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0]        lp_ctrl_reg, lp_ctrl_next;
    logic [7:0]        cal_cfg_reg, cal_cfg_next;
    logic [7:0]        soft_trig_reg, soft_trig_next;
    logic [7:0]        bg_ctrl_reg, bg_ctrl_next;
    logic [7:0]        gain_reg, gain_next;
    logic [7:0]        ref_reg, ref_next;
    logic [7:0]        term_reg [IN_COUNT];
    logic [7:0]        term_next [IN_COUNT];
    logic              fuse_loaded_reg, fuse_loaded_next;
    logic [7:0]        rdata_next;
    logic              pin_sync;
    logic              cal_trigger;
    logic              lp_active;
    logic              pin_paced;
    logic [2:0]        idle_interval_sel;
    logic [1:0]        settle_interval_sel;
    lpc_state_t        state_reg, state_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [CNT_W-1:0]  idle_len;
    logic [CNT_W-1:0]  settle_len;

    lpc_sync u_pin_sync
    (
        .mclk  (mclk),
        .nrst  (nrst),
        .d_in  (trigger_pin),
        .d_out (pin_sync)
    );

    assign idle_interval_sel   = lp_ctrl_reg[LP_IDLE_LSB +: 3];
    assign settle_interval_sel = lp_ctrl_reg[LP_SETTLE_LSB +: 2];
    assign pin_paced           = lp_ctrl_reg[LP_PIN_BIT];
    assign lp_active = lp_ctrl_reg[LOWPOWER_CAL_ON_BIT] & bg_ctrl_reg[BG_ON_BIT];
    assign cal_trigger = cal_cfg_reg[TRIG_SRC_BIT] ? pin_sync
                                                   : soft_trig_reg[SOFT_TRIG_BIT];

    always_comb
    begin
        case (idle_interval_sel)
            3'h0: idle_len = IDLE_CNT_0;
            3'h1: idle_len = IDLE_CNT_1;
            3'h2: idle_len = IDLE_CNT_2;
            3'h3: idle_len = IDLE_CNT_3;
            3'h4: idle_len = IDLE_CNT_4;
            3'h5: idle_len = IDLE_CNT_5;
            3'h6: idle_len = IDLE_CNT_6;
            default: idle_len = IDLE_CNT_7;
        endcase
        case (settle_interval_sel)
            2'h0: settle_len = IDLE_CNT_0;
            2'h1: settle_len = IDLE_CNT_2;
            2'h2: settle_len = IDLE_CNT_3;
            default: settle_len = IDLE_CNT_4;
        endcase
    end

    // ************************************************************
    // Register writes, fuse load and read data
    // ************************************************************
    // The fuse store arrives some cycles after reset, so the trims load on its first valid.
    always_comb
    begin
        lp_ctrl_next     = lp_ctrl_reg;
        cal_cfg_next     = cal_cfg_reg;
        soft_trig_next   = soft_trig_reg;
        bg_ctrl_next     = bg_ctrl_reg;
        gain_next        = gain_reg;
        ref_next         = ref_reg;
        term_next        = term_reg;
        fuse_loaded_next = fuse_loaded_reg | fuse_valid;
        if (fuse_valid && !fuse_loaded_reg)
        begin
            gain_next = fuse_gain;
            ref_next  = {4'h0, fuse_reference};
            for (int i = 0; i < IN_COUNT; i++)
            begin
                term_next[i] = fuse_term[i];
            end
        end
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_LP_CONTROL: lp_ctrl_next   = reg_wdata;
                OFS_CAL_CONFIG: cal_cfg_next   = reg_wdata;
                OFS_SOFT_TRIG:  soft_trig_next = reg_wdata;
                OFS_BG_CONTROL: bg_ctrl_next   = reg_wdata;
                OFS_GAIN:       gain_next      = reg_wdata;
                OFS_REFERENCE:  ref_next       = reg_wdata;
                default:        ;
            endcase
        end
        rdata_next = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_LP_CONTROL: rdata_next = lp_ctrl_reg;
                OFS_CAL_CONFIG: rdata_next = cal_cfg_reg;
                OFS_SOFT_TRIG:  rdata_next = soft_trig_reg;
                OFS_BG_CONTROL: rdata_next = bg_ctrl_reg;
                OFS_GAIN:       rdata_next = gain_reg;
                OFS_REFERENCE:  rdata_next = ref_reg;
                OFS_LP_STATUS:  rdata_next = {4'h0, core_sleep, state_reg};
                default:        rdata_next = 8'h00;
            endcase
            for (int i = 0; i < IN_COUNT; i++)
            begin
                if (reg_addr == OFS_TERM_A + ADDR_W'(i))
                begin
                    rdata_next = term_reg[i];
                end
            end
        end
    end

    generate
        for (genvar g = 0; g < IN_COUNT; g++)
        begin : g_term
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    term_reg[g] <= RST_FUSE_PLAIN;
                end
                else if (reg_wr && reg_addr == OFS_TERM_A + ADDR_W'(g))
                begin
                    term_reg[g] <= reg_wdata;
                end
                else
                begin
                    term_reg[g] <= term_next[g];
                end
            end
            assign input_termination[g] = term_reg[g];
        end
    endgenerate

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lp_ctrl_reg     <= RST_LP_CONTROL;
            cal_cfg_reg     <= RST_CAL_CONFIG;
            soft_trig_reg   <= RST_SOFT_TRIG;
            bg_ctrl_reg     <= RST_BG_CONTROL;
            gain_reg        <= RST_FUSE_PLAIN;
            ref_reg         <= RST_FUSE_PLAIN;
            fuse_loaded_reg <= 1'b0;
            reg_rdata       <= 8'h00;
        end
        else
        begin
            lp_ctrl_reg     <= lp_ctrl_next;
            cal_cfg_reg     <= cal_cfg_next;
            soft_trig_reg   <= soft_trig_next;
            bg_ctrl_reg     <= bg_ctrl_next;
            gain_reg        <= gain_next;
            ref_reg         <= ref_next;
            fuse_loaded_reg <= fuse_loaded_next;
            reg_rdata       <= rdata_next;
        end
    end

    assign core_gain_adjust = gain_reg;
    assign reference_adjust = ref_reg[REF_W-1:0];

    // ************************************************************
    // Offline core scheduler
    // ************************************************************
    // Counters are 41 bits wide so the longest idle code is exact; they are zero in calibration and keep their last value when the scheduler drops to off.
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cal_start  = 1'b0;
        core_sleep = 1'b0;
        case (state_reg)
            LPC_OFF:
            begin
                if (lp_active)
                begin
                    state_next = LPC_SLEEP;
                    cnt_next   = idle_len;
                end
            end
            LPC_SLEEP:
            begin
                core_sleep = 1'b1;
                if (!lp_active)
                begin
                    state_next = LPC_OFF;
                end
                else if (pin_paced)
                begin
                    if (!cal_trigger)
                    begin
                        state_next = LPC_SETTLE;
                        cnt_next   = settle_len;
                    end
                end
                else if (cnt_reg <= CNT_W'(1))
                begin
                    state_next = LPC_SETTLE;
                    cnt_next   = settle_len;
                end
                else
                begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            LPC_SETTLE:
            begin
                if (!lp_active)
                begin
                    state_next = LPC_OFF;
                end
                else if (cnt_reg <= CNT_W'(1))
                begin
                    state_next = LPC_CAL;
                    cnt_next   = '0;
                    cal_start  = 1'b1;
                end
                else
                begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            LPC_CAL:
            begin
                if (!lp_active)
                begin
                    state_next = LPC_OFF;
                end
                else if (cal_done)
                begin
                    state_next = LPC_SLEEP;
                    cnt_next   = idle_len;
                end
            end
            default:
            begin
                state_next = LPC_OFF;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= LPC_OFF;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

endmodule
`default_nettype wire

/* lpc_regs_properties.sv */
// Concurrent checks on the ports of the calibration and trim bank.
`timescale 1ns/1ps
`default_nettype none
module lpc_regs_properties
    import lpc_pkg::*;
#(
    parameter int unsigned IN_COUNT = 3
)
(
    // Clock, reset and register port
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Fuses and pins
    input wire logic [DATA_W-1:0] fuse_gain,
    input wire logic [REF_W-1:0]  fuse_reference,
    input wire logic [DATA_W-1:0] fuse_term [IN_COUNT],
    input wire logic              fuse_valid,
    input wire logic              trigger_pin,
    input wire logic              cal_done,
    // Controls
    input wire logic [DATA_W-1:0] core_gain_adjust,
    input wire logic [REF_W-1:0]  reference_adjust,
    input wire logic [DATA_W-1:0] input_termination [IN_COUNT],
    input wire logic              core_sleep,
    input wire logic              cal_start
);
    // ************************************************************
    // Shadow state
    // ************************************************************
    // The sleep range allows one cycle of slack and the settle range one cycle either side, for where the state edge falls.
    localparam int SLP_LO = 1151;
    localparam int SLP_HI = 1152;
    localparam int SET_LO = 1150;
    localparam int SET_HI = 1152;
    logic [7:0]  lp_ctl_sh;
    logic        bg_sh;
    logic        src_sh;
    logic        fuse_seen;
    logic [15:0] sleep_cnt;
    logic [15:0] gap_cnt;
    logic        act;

    assign act = lp_ctl_sh[LOWPOWER_CAL_ON_BIT] & bg_sh;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lp_ctl_sh <= 8'h88;
            bg_sh     <= 1'b0;
            src_sh    <= 1'b0;
            fuse_seen <= 1'b0;
            sleep_cnt <= 16'h0000;
            gap_cnt   <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == OFS_LP_CONTROL)
                lp_ctl_sh <= reg_wdata;
            if (reg_wr && reg_addr == OFS_BG_CONTROL)
                bg_sh <= reg_wdata[BG_ON_BIT];
            if (reg_wr && reg_addr == OFS_CAL_CONFIG)
                src_sh <= reg_wdata[TRIG_SRC_BIT];
            fuse_seen <= fuse_seen | fuse_valid;
            sleep_cnt <= core_sleep ? sleep_cnt + 16'h0001 : 16'h0000;
            gap_cnt   <= core_sleep ? 16'h0000 : gap_cnt + 16'h0001;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_gain_read_back: assert property (
        reg_rd && reg_addr == OFS_GAIN |=> reg_rdata == $past(core_gain_adjust))
        else $error("gain read does not match gain output");
    a_gain_write_lands: assert property (
        reg_wr && reg_addr == OFS_GAIN |=> core_gain_adjust == $past(reg_wdata))
        else $error("gain write not applied");
    a_ref_write_lands: assert property (
        reg_wr && reg_addr == OFS_REFERENCE
        |=> {4'h0, reference_adjust} == ($past(reg_wdata) & 8'h0F))
        else $error("reference write not applied");
    a_term_write_lands: assert property (
        reg_wr && reg_addr == OFS_TERM_B |=> input_termination[1] == $past(reg_wdata))
        else $error("termination write not applied");
    a_fuse_load_once: assert property (
        fuse_valid && !fuse_seen && !reg_wr
        |=> core_gain_adjust == $past(fuse_gain) && reference_adjust == $past(fuse_reference))
        else $error("factory values not loaded");
    a_sleep_len_code: assert property (
        $fell(core_sleep) && act && $past(act) && !lp_ctl_sh[LP_PIN_BIT]
        && lp_ctl_sh[7:5] == 3'h0 |-> sleep_cnt inside {[SLP_LO:SLP_HI]})
        else $error("autonomous sleep length wrong");
    a_settle_len_code: assert property (
        cal_start && lp_ctl_sh[4:3] == 2'h0 |-> gap_cnt inside {[SET_LO:SET_HI]})
        else $error("settle length before calibration wrong");
    // The pin reaches the scheduler two flops late, so three high samples are needed.
    a_pin_holds_sleep: assert property (
        core_sleep && act && lp_ctl_sh[LP_PIN_BIT] && src_sh && trigger_pin
        && $past(trigger_pin) && $past(trigger_pin, 2) && !reg_wr |=> core_sleep)
        else $error("core woke while trigger high");
    a_inactive_no_sleep: assert property (!act |=> !core_sleep)
        else $error("core asleep while low power inactive");
endmodule

bind lpc_regs lpc_regs_properties #(.IN_COUNT(IN_COUNT)) lpc_regs_properties_inst (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_gain(fuse_gain),
    .fuse_reference(fuse_reference), .fuse_term(fuse_term), .fuse_valid(fuse_valid),
    .trigger_pin(trigger_pin), .cal_done(cal_done),
    .core_gain_adjust(core_gain_adjust), .reference_adjust(reference_adjust),
    .input_termination(input_termination), .core_sleep(core_sleep), .cal_start(cal_start)
);
`default_nettype wire

/* lpc_sync.sv */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module lpc_sync
    import lpc_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // Data
    input  wire logic d_in,
    output logic      d_out
);

    logic meta_reg;
    logic meta_next;
    logic out_next;

    always_comb
    begin
        meta_next = d_in;
        out_next  = meta_reg;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= 1'b0;
            d_out    <= 1'b0;
        end
        else
        begin
            meta_reg <= meta_next;
            d_out    <= out_next;
        end
    end

endmodule
`default_nettype wire

/* test_lpc_regs.sv */
// Self-checking testbench for the calibration and trim bank.
`timescale 1ns/1ps
`default_nettype none
module test_lpc_regs
    import lpc_pkg::*;
;
    logic              mclk, nrst, reg_wr, reg_rd, fuse_valid, trigger_pin, cal_done;
    logic              core_sleep, cal_start;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, fuse_gain, core_gain_adjust;
    logic [REF_W-1:0]  fuse_reference, reference_adjust;
    logic [DATA_W-1:0] fuse_term [3];
    logic [DATA_W-1:0] input_termination [3];
    logic [ADDR_W-1:0] trim_addr [5];
    logic [DATA_W-1:0] trim_val [5];
    int                err_total, checks_done, n;

    lpc_regs #(.IN_COUNT(3)) lpc_regs_inst (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_gain(fuse_gain),
        .fuse_reference(fuse_reference), .fuse_term(fuse_term), .fuse_valid(fuse_valid),
        .trigger_pin(trigger_pin), .cal_done(cal_done), .core_gain_adjust(core_gain_adjust),
        .reference_adjust(reference_adjust), .input_termination(input_termination),
        .core_sleep(core_sleep), .cal_start(cal_start)
    );

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Errors %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // A wait that runs out of cycles fails its compare and ends the run.
    task automatic wait_on(input bit sel, input logic lvl, input int lim);
        n = 0;
        while ((sel ? cal_start : core_sleep) !== lvl && n < lim)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(8'(sel ? cal_start : core_sleep), 8'(lvl));
        if ((sel ? cal_start : core_sleep) !== lvl)
            stop_test();
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {nrst, reg_wr, reg_rd, fuse_valid, cal_done, reg_addr, reg_wdata} = '0;
        {err_total, checks_done, n} = '0;
        trigger_pin = 1'b1;
        fuse_gain = 8'hA5;
        fuse_reference = 4'h9;
        fuse_term = '{8'h11, 8'h22, 8'h33};
        trim_addr = '{OFS_GAIN, OFS_REFERENCE, OFS_TERM_A, OFS_TERM_B, OFS_TERM_C};
        trim_val = '{8'h3C, 8'h06, 8'hC3, 8'h7E, 8'h81};
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_LP_CONTROL, 8'h88);
        rd(OFS_GAIN, 8'h00);
        rd(OFS_SOFT_TRIG, 8'h01);
        @(posedge mclk);
        fuse_valid <= 1'b1;
        @(posedge mclk);
        fuse_gain <= 8'h5A;
        rd(OFS_GAIN, 8'hA5);
        rd(OFS_REFERENCE, 8'h09);
        for (int i = 0; i < 3; i++)
            rd(trim_addr[i + 2], fuse_term[i]);
        for (int i = 0; i < 5; i++)
        begin
            wr(trim_addr[i], trim_val[i]);
            rd(trim_addr[i], trim_val[i]);
        end
        check(core_gain_adjust, 8'h3C);
        check(8'(reference_adjust), 8'h06);
        for (int i = 0; i < 3; i++)
            check(input_termination[i], trim_val[i + 2]);
        wr(9'h100, 8'hFF);
        rd(9'h100, 8'h00);
        wr(OFS_LP_STATUS, 8'hFF);
        rd(OFS_LP_STATUS, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_LP_CONTROL, {i[2:0], i[1:0], 3'b000});
            rd(OFS_LP_CONTROL, {i[2:0], i[1:0], 3'b000});
        end
        // Enable alone must not sleep the core while background calibration is off.
        wr(OFS_LP_CONTROL, 8'h01);
        repeat (5) @(posedge mclk);
        #1;
        check(8'(core_sleep), 8'h00);
        wr(OFS_BG_CONTROL, 8'h01);
        wait_on(0, 1'b1, 4);
        wait_on(0, 1'b0, 1300);
        check(8'(n inside {[1151:1152]}), 8'h01);
        rd(OFS_LP_STATUS, 8'h02);
        wait_on(1, 1'b1, 1200);
        @(posedge mclk);
        cal_done <= 1'b1;
        @(posedge mclk);
        cal_done <= 1'b0;
        wait_on(0, 1'b1, 4);
        rd(OFS_LP_STATUS, 8'h09);
        // Pin-paced with idle code 0: a timed wake would show after 1152 cycles.
        wr(OFS_CAL_CONFIG, 8'h01);
        wr(OFS_LP_CONTROL, 8'h03);
        repeat (1300) @(posedge mclk);
        #1;
        check(8'(core_sleep), 8'h01);
        @(posedge mclk);
        trigger_pin <= 1'b0;
        wait_on(0, 1'b0, 5);
        // The trigger must be high through the synchroniser before the core returns to sleep.
        trigger_pin <= 1'b1;
        wait_on(1, 1'b1, 1200);
        @(posedge mclk);
        cal_done <= 1'b1;
        @(posedge mclk);
        cal_done <= 1'b0;
        wait_on(0, 1'b1, 5);
        wr(OFS_CAL_CONFIG, 8'h00);
        @(posedge mclk);
        trigger_pin <= 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        check(8'(core_sleep), 8'h01);
        wr(OFS_BG_CONTROL, 8'h00);
        wait_on(0, 1'b0, 3);
        wr(OFS_BG_CONTROL, 8'h01);
        wait_on(0, 1'b1, 4);
        wr(OFS_SOFT_TRIG, 8'h00);
        wait_on(0, 1'b0, 5);
        wr(OFS_LP_CONTROL, 8'h89);
        rd(OFS_LP_CONTROL, 8'h89);
        // A second reset must restore defaults and allow a fresh fuse load.
        @(posedge mclk);
        {nrst, fuse_valid} <= 2'b00;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_LP_CONTROL, 8'h88);
        rd(OFS_GAIN, 8'h00);
        @(posedge mclk);
        fuse_valid <= 1'b1;
        rd(OFS_GAIN, 8'h5A);
        stop_test();
    end
endmodule
`default_nettype wire
